// ==== src/eq_ctrl_regs.vh ====
`ifndef EQ_CTRL_REGS_VH
`define EQ_CTRL_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_CH0_BOOST      8'h03
`define REG_CH12_BOOST     8'h04
`define REG_ENABLE_SRC     8'h07
`define REG_OUT_AMPL       8'h08

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_CH0_BOOST      8'h07
`define RST_CH12_BOOST     8'h77
`define RST_ENABLE_SRC     8'h00
`define RST_OUT_AMPL       8'h78

// ----------------------------------------
// Writable bit masks (others reserved)
// ----------------------------------------
`define MSK_CH0_BOOST      8'h0f
`define MSK_CH12_BOOST     8'hff
`define MSK_ENABLE_SRC     8'h01
`define MSK_OUT_AMPL       8'h0c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_ENABLE_SRC     0
`define BIT_REG_STANDBY    3
`define FLD_AMPL_HI        3
`define FLD_AMPL_LO        2
`define FLD_BC0_HI         2
`define FLD_BC0_LO         0
`define FLD_BC1_HI         2
`define FLD_BC1_LO         0
`define FLD_BC2_HI         6
`define FLD_BC2_LO         4

`define BOOST_W            3
`define RD_UNMAPPED        8'h00

`endif

// ==== src/ctrl_reg.v ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// One control register with reserved-bit protection
// ----------------------------------------
module ctrl_reg #(
   parameter [7:0] RST_VAL = 8'h00,
   parameter [7:0] WR_MASK = 8'hff
) (
   // Clock and reset
   input  wire       clk,
   input  wire       rst_b,
   // Write side
   input  wire       wr_en,
   input  wire [7:0] wr_data,
   // Contents
   output reg  [7:0] q_r
);

   wire [7:0] q_nxt;

   // Reserved bits keep their reset value whatever is written
   assign q_nxt = (wr_data & WR_MASK) | (RST_VAL & ~WR_MASK);

   always @(posedge clk) begin
      if (!rst_b) begin
         q_r <= RST_VAL;
      end else if (wr_en) begin
         q_r <= q_nxt;
      end
   end

endmodule

`default_nettype wire

// ==== src/sync2.v ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Two-flop synchroniser for pin levels
// ----------------------------------------
module sync2 #(
   parameter       W      = 1,
   parameter [0:0] RST_LV = 1'b0
) (
   // Clock and reset
   input  wire         clk,
   input  wire         rst_b,
   // Level in and out
   input  wire [W-1:0] d,
   output reg  [W-1:0] q_r
);

   reg [W-1:0] meta_r;

   always @(posedge clk) begin
      if (!rst_b) begin
         meta_r <= {W{RST_LV}};
         q_r    <= {W{RST_LV}};
      end else begin
         meta_r <= d;
         q_r    <= meta_r;
      end
   end

endmodule

`default_nettype wire

// ==== src/eq_boost_enable_control.v ====
`timescale 1ns/1ps
`default_nettype none
`include "eq_ctrl_regs.vh"

module eq_boost_enable_control #(
   parameter BW = 3
) (
   // Clock and reset
   input  wire          clk,
   input  wire          rst_b,
   // Register port, decoded from the SMBus slave
   input  wire          reg_wr,
   input  wire          reg_rd,
   input  wire [7:0]    reg_addr,
   input  wire [7:0]    reg_wdata,
   output reg  [7:0]    reg_rdata_r,
   // Pins
   input  wire          boost_source_select,
   input  wire [BW-1:0] boost_strap_pins,
   input  wire          enable_pin,
   // Channel controls
   output reg  [BW-1:0] ch0_boost_r,
   output reg  [BW-1:0] ch1_boost_r,
   output reg  [BW-1:0] ch2_boost_r,
   output reg  [1:0]    out_ampl_r,
   output reg           active_r,
   output reg           chan_pwr_dn_r,
   output wire          ctrl_if_on,
   output wire          clk_detect_on
);

   // ----------------------------------------
   // Register bank
   // ----------------------------------------
   wire [7:0] ch0_q;
   wire [7:0] ch12_q;
   wire [7:0] en_src_q;
   wire [7:0] ampl_q;

   // Writes land on each rising clock edge while the bus write strobe is high
   ctrl_reg #(.RST_VAL(`RST_CH0_BOOST), .WR_MASK(`MSK_CH0_BOOST)) u_ch0 (
      .clk     (clk),
      .rst_b   (rst_b),
      .wr_en   (reg_wr && reg_addr == `REG_CH0_BOOST),
      .wr_data (reg_wdata),
      .q_r     (ch0_q)
   );

   ctrl_reg #(.RST_VAL(`RST_CH12_BOOST), .WR_MASK(`MSK_CH12_BOOST)) u_ch12 (
      .clk     (clk),
      .rst_b   (rst_b),
      .wr_en   (reg_wr && reg_addr == `REG_CH12_BOOST),
      .wr_data (reg_wdata),
      .q_r     (ch12_q)
   );

   ctrl_reg #(.RST_VAL(`RST_ENABLE_SRC), .WR_MASK(`MSK_ENABLE_SRC)) u_en (
      .clk     (clk),
      .rst_b   (rst_b),
      .wr_en   (reg_wr && reg_addr == `REG_ENABLE_SRC),
      .wr_data (reg_wdata),
      .q_r     (en_src_q)
   );

   ctrl_reg #(.RST_VAL(`RST_OUT_AMPL), .WR_MASK(`MSK_OUT_AMPL)) u_ampl (
      .clk     (clk),
      .rst_b   (rst_b),
      .wr_en   (reg_wr && reg_addr == `REG_OUT_AMPL),
      .wr_data (reg_wdata),
      .q_r     (ampl_q)
   );

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   reg [7:0] rdata_nxt;

   always @* begin
      case (reg_addr)
         `REG_CH0_BOOST:  rdata_nxt = ch0_q;
         `REG_CH12_BOOST: rdata_nxt = ch12_q;
         `REG_ENABLE_SRC: rdata_nxt = en_src_q;
         `REG_OUT_AMPL:   rdata_nxt = ampl_q;
         default:         rdata_nxt = `RD_UNMAPPED;
      endcase
   end

   always @(posedge clk) begin
      if (!rst_b) begin
         reg_rdata_r <= `RD_UNMAPPED;
      end else if (reg_rd) begin
         reg_rdata_r <= rdata_nxt;
      end
   end

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Source select resets high so a floating pin means strap control
   wire          fsel_s;
   wire [BW-1:0] strap_s;
   wire          en_pin_s;

   sync2 #(.W(1), .RST_LV(1'b1)) u_sync_fsel (
      .clk   (clk),
      .rst_b (rst_b),
      .d     (boost_source_select),
      .q_r   (fsel_s)
   );

   sync2 #(.W(BW), .RST_LV(1'b0)) u_sync_strap (
      .clk   (clk),
      .rst_b (rst_b),
      .d     (boost_strap_pins),
      .q_r   (strap_s)
   );

   sync2 #(.W(1), .RST_LV(1'b0)) u_sync_en (
      .clk   (clk),
      .rst_b (rst_b),
      .d     (enable_pin),
      .q_r   (en_pin_s)
   );

   // ----------------------------------------
   // Boost selection
   // ----------------------------------------
   wire [BW-1:0] reg_bc0;
   wire [BW-1:0] reg_bc1;
   wire [BW-1:0] reg_bc2;

   // Same 3-bit code, 000 min to 111 max, for pins and fields
   assign reg_bc0 = ch0_q[`FLD_BC0_HI:`FLD_BC0_LO];
   assign reg_bc1 = ch12_q[`FLD_BC1_HI:`FLD_BC1_LO];
   assign reg_bc2 = ch12_q[`FLD_BC2_HI:`FLD_BC2_LO];

   always @(posedge clk) begin
      if (!rst_b) begin
         ch0_boost_r <= {BW{1'b0}};
         ch1_boost_r <= {BW{1'b0}};
         ch2_boost_r <= {BW{1'b0}};
      end else if (fsel_s) begin
         // One strap code shared by every channel
         ch0_boost_r <= strap_s;
         ch1_boost_r <= strap_s;
         ch2_boost_r <= strap_s;
      end else begin
         // Each channel takes its own field
         ch0_boost_r <= reg_bc0;
         ch1_boost_r <= reg_bc1;
         ch2_boost_r <= reg_bc2;
      end
   end

   // ----------------------------------------
   // Enable resolution and device state
   // ----------------------------------------
   localparam ST_STANDBY = 2'b01;
   localparam ST_ACTIVE  = 2'b10;

   reg  [1:0] state_r;
   reg  [1:0] state_nxt;
   wire       want_active;

   // Register source ignores the pin; pin source ignores the bit
   assign want_active = en_src_q[`BIT_ENABLE_SRC] ?
                        ~ch0_q[`BIT_REG_STANDBY] :
                        en_pin_s;

   always @* begin
      case (state_r)
         ST_STANDBY: state_nxt = want_active ? ST_ACTIVE : ST_STANDBY;
         ST_ACTIVE:  state_nxt = want_active ? ST_ACTIVE : ST_STANDBY;
         default:    state_nxt = ST_STANDBY;
      endcase
   end

   always @(posedge clk) begin
      if (!rst_b) begin
         state_r       <= ST_STANDBY;
         active_r      <= 1'b0;
         chan_pwr_dn_r <= 1'b1;
      end else begin
         state_r       <= state_nxt;
         active_r      <= (state_nxt == ST_ACTIVE);
         chan_pwr_dn_r <= (state_nxt != ST_ACTIVE);
      end
   end

   // Control port and clock detect never power down
   assign ctrl_if_on    = 1'b1;
   assign clk_detect_on = 1'b1;

   // ----------------------------------------
   // Output amplitude
   // ----------------------------------------
   // Applies to data and clock drivers alike
   localparam [7:0] AMPL_RST = `RST_OUT_AMPL;

   always @(posedge clk) begin
      if (!rst_b) begin
         out_ampl_r <= AMPL_RST[`FLD_AMPL_HI:`FLD_AMPL_LO];
      end else begin
         out_ampl_r <= ampl_q[`FLD_AMPL_HI:`FLD_AMPL_LO];
      end
   end

endmodule

`default_nettype wire

// ==== sim/eq_ctrl_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module eq_ctrl_asserts #(
   parameter BW = 3
) (
   // Clock and reset
   input wire logic          clk,
   input wire logic          rst_b,
   // Register port
   input wire logic          reg_wr,
   input wire logic          reg_rd,
   input wire logic [7:0]    reg_addr,
   input wire logic [7:0]    reg_wdata,
   input wire logic [7:0]    reg_rdata_r,
   // Pins
   input wire logic          boost_source_select,
   input wire logic [BW-1:0] boost_strap_pins,
   input wire logic          enable_pin,
   // Channel controls
   input wire logic [BW-1:0] ch0_boost_r,
   input wire logic [BW-1:0] ch1_boost_r,
   input wire logic [BW-1:0] ch2_boost_r,
   input wire logic [1:0]    out_ampl_r,
   input wire logic          active_r,
   input wire logic          chan_pwr_dn_r,
   input wire logic          ctrl_if_on,
   input wire logic          clk_detect_on
);
   // ------
   // Shadow of the written fields
   // ------
   logic [3:0] m03_r;
   logic [7:0] m04_r;
   logic [1:0] m08_r;
   logic       src_r;
   always @(posedge clk) begin
      if (!rst_b) begin
         m03_r <= 4'h7;
         m04_r <= 8'h77;
         m08_r <= 2'h2;
         src_r <= 1'b0;
      end else if (reg_wr) begin
         if (reg_addr == 8'h03) m03_r <= reg_wdata[3:0];
         if (reg_addr == 8'h04) m04_r <= reg_wdata;
         if (reg_addr == 8'h08) m08_r <= reg_wdata[3:2];
         if (reg_addr == 8'h07) src_r <= reg_wdata[0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   strap_boost_a: assert property (
      (boost_source_select && $stable(boost_strap_pins))[*4] |-> ch0_boost_r == boost_strap_pins
      && ch1_boost_r == boost_strap_pins && ch2_boost_r == boost_strap_pins) else $error("strap");
   reg_boost_a: assert property (
      (!boost_source_select && $stable(m03_r) && $stable(m04_r))[*4] |-> ch0_boost_r == m03_r[2:0]
      && ch1_boost_r == m04_r[2:0] && ch2_boost_r == m04_r[6:4]) else $error("reg boost");
   pin_enable_a: assert property (
      (!src_r && $stable(enable_pin))[*4] |-> active_r == enable_pin) else $error("pin enable");
   reg_enable_a: assert property (
      (src_r && $stable(m03_r))[*2] |-> active_r == !m03_r[3]) else $error("reg enable");
   standby_ctrl_a: assert property (
      chan_pwr_dn_r == !active_r && ctrl_if_on && clk_detect_on) else $error("standby");
   ampl_set_a: assert property (
      $stable(m08_r)[*2] |-> out_ampl_r == m08_r) else $error("amplitude");
   rd_en_src_a: assert property (
      reg_rd && reg_addr == 8'h07 |=> reg_rdata_r == {7'h00, src_r}) else $error("read 07");
   rd_ampl_a: assert property (
      reg_rd && reg_addr == 8'h08 |=> reg_rdata_r == {4'h7, m08_r, 2'h0}) else $error("read 08");
   cover property (src_r && m03_r[3]);
   cover property (boost_source_select && boost_strap_pins == 3'h7);
   cover property (reg_rd && reg_addr == 8'h20);
endmodule
bind eq_boost_enable_control eq_ctrl_asserts #(.BW(BW)) chk (.clk, .rst_b, .reg_wr, .reg_rd,
   .reg_addr, .reg_wdata, .reg_rdata_r, .boost_source_select, .boost_strap_pins, .enable_pin,
   .ch0_boost_r, .ch1_boost_r, .ch2_boost_r, .out_ampl_r, .active_r, .chan_pwr_dn_r,
   .ctrl_if_on, .clk_detect_on);
`default_nettype wire

// ==== sim/host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_model (
   // Clock
   input  wire logic       clk,
   // Register port
   output var  logic       reg_wr,
   output var  logic       reg_rd,
   output var  logic [7:0] reg_addr,
   output var  logic [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata_r,
   // Straps
   output var  logic       boost_source_select,
   output var  logic [2:0] boost_strap_pins,
   output var  logic       enable_pin
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      boost_source_select = 1'b1; // Pull-up while unstrapped
      boost_strap_pins = 3'h0;
      enable_pin = 1'b0;
   end
   // One byte access; read data is taken one cycle after the strobe
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      @(negedge clk);
      reg_wr = w;
      reg_rd = !w;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      // Released lines must not look like a held value
      reg_addr = ~a;
      reg_wdata = ~d;
      q = reg_rdata_r;
   endtask
   task automatic pins(input logic s, input logic [2:0] b, input logic e);
      @(negedge clk);
      boost_source_select = s;
      boost_strap_pins = b;
      enable_pin = e;
   endtask
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic       clk;
   logic       rst_b;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata_r;
   logic       src_sel;
   logic [2:0] strap;
   logic       en;
   logic [2:0] ch0;
   logic [2:0] ch1;
   logic [2:0] ch2;
   logic [1:0] ampl;
   logic       active_r;
   logic       pwr_dn;
   logic       if_on;
   logic       det_on;
   logic [7:0] q;
   int         errors;
   int         tests_run;
   int         cyc;
   host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .boost_source_select(src_sel),
      .boost_strap_pins(strap), .enable_pin(en));
   eq_boost_enable_control dut (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
      .boost_source_select(src_sel), .boost_strap_pins(strap), .enable_pin(en),
      .ch0_boost_r(ch0),
      .ch1_boost_r(ch1), .ch2_boost_r(ch2), .out_ampl_r(ampl), .active_r(active_r),
      .chan_pwr_dn_r(pwr_dn), .ctrl_if_on(if_on), .clk_detect_on(det_on));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      host.acc(1'b0, a, 8'h00, q);
      chk(q, e);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.acc(1'b1, a, d, q);
   endtask
   task automatic end_sim;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic t_reset;
      chk({6'h00, ampl}, 8'h02);
      rd(8'h03, 8'h07);
      rd(8'h04, 8'h77);
      rd(8'h07, 8'h00);
      rd(8'h08, 8'h78);
      rd(8'h20, 8'h00);
      chk({7'h00, active_r}, 8'h00);
      chk({2'h0, ch2, ch1, ch0}, 8'h00);
   endtask
   task automatic t_pins;
      wr(8'h04, 8'h52);
      for (int i = 0; i < 8; i++) begin
         host.pins(1'b1, i[2:0], 1'b1);
         repeat (4) @(negedge clk);
         chk({5'h00, ch0}, {5'h00, i[2:0]});
         chk({2'h0, ch2, ch1}, {2'h0, i[2:0], i[2:0]});
      end
   endtask
   task automatic t_regs;
      host.pins(1'b0, 3'h7, 1'b1);
      wr(8'h03, 8'hf5);
      wr(8'h04, 8'h36);
      repeat (5) @(negedge clk);
      chk({2'h0, ch2, ch1, ch0}, {2'h0, 3'h3, 3'h6, 3'h5});
      rd(8'h03, 8'h05);
   endtask
   task automatic t_enable;
      wr(8'h03, 8'h0d);
      repeat (3) @(negedge clk);
      chk({6'h00, active_r, pwr_dn}, 8'h02);
      wr(8'h07, 8'hff);
      rd(8'h07, 8'h01);
      chk({5'h00, active_r, if_on, det_on}, 8'h03);
      host.pins(1'b0, 3'h7, 1'b0);
      wr(8'h03, 8'h05);
      repeat (4) @(negedge clk);
      chk({7'h00, active_r}, 8'h01);
      wr(8'h07, 8'h00);
      repeat (2) @(negedge clk);
      chk({7'h00, active_r}, 8'h00);
   endtask
   task automatic t_ampl;
      for (int c = 0; c < 4; c++) begin
         wr(8'h08, {4'h0, c[1:0], 2'h3});
         rd(8'h08, {4'h7, c[1:0], 2'h0});
         chk({6'h00, ampl}, {6'h00, c[1:0]});
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         end_sim;
      end
   end
   initial begin
      rst_b = 1'b0;
      repeat (3) @(negedge clk);
      rst_b = 1'b1;
      t_reset;
      t_pins;
      t_regs;
      t_enable;
      t_ampl;
      end_sim;
   end
endmodule
`default_nettype wire
